// file: hw/eeprom_host.sv
// Host controller driving a byte-wide parallel EEPROM through its pins
// Contract
// - Writes pulse write strobe low under chip select, output high.
// - Each further byte follows within 150 us of the previous.
// - Upper address bits stay the same across one page load.
// - Three protection command writes precede every write.
// - Prefix repeats every write, with page-load timing.
`timescale 1ns/1ps
`include "eeprom_host_consts.svh"
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter longint WC_CYCLES  = `WC_CYC,
  parameter longint PU_CYCLES  = `PU_CYC,
  parameter int     BLC_CYCLES = `BLC_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request side
  input  wire logic        req_valid,
  input  wire host_req_s   req,
  input  wire logic        page_last,
  output logic             req_ready,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             wr_done,
  output logic             wr_timeout,
  // Device pins
  output pin_ctl_s         pins,
  output logic [7:0]       data_lines_o,
  output logic             data_lines_oe_n,
  input  wire logic [7:0]  data_lines_i
);
  localparam int TW = 24;
  localparam int LW = 32;

  // Counters are TW and LW bits wide; larger figures would wrap
  if (BLC_CYCLES <= `WP_CYC + `WH_CYC + 8 || BLC_CYCLES >= 2**TW)
  begin
    $error("BLC_CYCLES out of range");
  end
  if (WC_CYCLES < 1 || PU_CYCLES < 1
      || WC_CYCLES >= 64'd4294967296 || PU_CYCLES >= 64'd4294967296)
  begin
    $error("WC_CYCLES or PU_CYCLES out of range");
  end

  typedef enum logic [3:0] {
    S_POWERUP, S_IDLE, S_CMD, S_WR_LOW, S_WR_HIGH, S_WAIT_NEXT,
    S_RD_ACC, S_RD_FLOAT, S_POLL_ACC, S_POLL_FLOAT
  } state_e;

  state_e       state_q;
  logic [1:0]   cmd_idx_q;
  logic         in_cmd_q;
  logic [8:0]   page_q;
  logic         page_open_q;
  logic [7:0]   last_data_q;
  logic [14:0]  last_addr_q;
  logic [LW-1:0] long_q;
  logic [TW-1:0] blc_q;
  logic [6:0]   bytes_q;
  logic         last_q;
  logic         poll_hit_q;
  logic         tog_prev_q;
  logic         t_load;
  logic [TW-1:0] t_count;
  logic         t_done;

  strobe_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (t_load),
    .count (t_count),
    .done  (t_done)
  );

  function automatic logic [22:0] cmd_word(input logic [1:0] i);
    case (i)
      2'd0:    cmd_word = {`PROT_ADDR0, `PROT_DATA0};
      2'd1:    cmd_word = {`PROT_ADDR1, `PROT_DATA1};
      default: cmd_word = {`PROT_ADDR2, `PROT_DATA2};
    endcase
  endfunction

  wire [22:0] cmd_first = cmd_word(2'd0);
  wire [22:0] cmd_next  = cmd_word(cmd_idx_q + 2'd1);

  // Request taken only in idle, or while a page load is open
  wire take = req_valid && req_ready;
  wire same_page = req.write && page_open_q
                   && (req.addr[14:`PAGE_LSB] == page_q);
  // Load closes on the last byte, the 64th byte or the deadline
  wire close_load = (state_q == S_WR_HIGH && t_done && !in_cmd_q
                     && (last_q || bytes_q == 7'(`PAGE_BYTES)))
                    || (state_q == S_WAIT_NEXT && !take && blc_q == '0);
  wire poll_end   = poll_hit_q || long_q == '0;
  wire poll_again = state_q == S_POLL_FLOAT && t_done && !poll_end;

  always_comb
  begin
    t_load  = 1'b0;
    t_count = '0;
    case (state_q)
      S_IDLE, S_WAIT_NEXT:
        if (take)
        begin
          t_load  = 1'b1;
          t_count = TW'(`WP_CYC);
        end
      S_CMD:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = TW'(`WP_CYC);
        end
      S_WR_LOW:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = TW'(`WH_CYC);
        end
      S_RD_ACC, S_POLL_ACC:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = TW'(`FL_CYC);
        end
      default:
      begin
        t_load  = 1'b0;
        t_count = '0;
      end
    endcase
    if (state_q == S_IDLE && take && !req.write)
      t_count = TW'(`RD_CYC);
    // A poll is a full read access, so it waits the access time too
    if (close_load || poll_again)
    begin
      t_load  = 1'b1;
      t_count = TW'(`RD_CYC);
    end
  end

  // Main sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= S_POWERUP;
      cmd_idx_q <= 2'd0;
      in_cmd_q  <= 1'b0;
      last_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_POWERUP:
          if (long_q == '0)
            state_q <= S_IDLE;
        S_IDLE:
          if (take && req.write)
          begin
            state_q   <= S_WR_LOW;
            in_cmd_q  <= 1'b1;
            cmd_idx_q <= 2'd0;
            last_q    <= page_last;
          end
          else if (take)
            state_q <= S_RD_ACC;
        S_WR_LOW:
          if (t_done)
            state_q <= S_WR_HIGH;
        S_WR_HIGH:
          if (t_done)
          begin
            if (in_cmd_q && cmd_idx_q != 2'd2)
            begin
              cmd_idx_q <= cmd_idx_q + 2'd1;
              state_q   <= S_CMD;
            end
            else if (in_cmd_q)
            begin
              in_cmd_q <= 1'b0;
              state_q  <= S_CMD;
            end
            else if (last_q || bytes_q == 7'(`PAGE_BYTES))
              state_q <= S_POLL_ACC;
            else
              state_q <= S_WAIT_NEXT;
          end
        S_CMD:
          if (t_done)
            state_q <= S_WR_LOW;
        S_WAIT_NEXT:
          if (take)
          begin
            state_q <= S_WR_LOW;
            last_q  <= page_last;
          end
          else if (blc_q == '0)
            state_q <= S_POLL_ACC;
        S_RD_ACC:
          if (t_done)
            state_q <= S_RD_FLOAT;
        S_RD_FLOAT:
          if (t_done)
            state_q <= S_IDLE;
        S_POLL_ACC:
          if (t_done)
            state_q <= S_POLL_FLOAT;
        S_POLL_FLOAT:
          if (t_done)
          begin
            if (poll_end)
              state_q <= S_IDLE;
            else
              state_q <= S_POLL_ACC;
          end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Power-up and write-cycle deadline counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      long_q <= LW'(PU_CYCLES);
    else if (close_load)
      long_q <= LW'(WC_CYCLES);
    else if (long_q != '0)
      long_q <= long_q - 1'b1;
  end

  // Byte load deadline, restarted by every data byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      blc_q <= '0;
    else if (state_q == S_WR_HIGH && t_done && !in_cmd_q)
      blc_q <= TW'(BLC_CYCLES - `WH_CYC - `WP_CYC - 4);
    else if (blc_q != '0)
      blc_q <= blc_q - 1'b1;
  end

  // Page tracking and last written byte for polling
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_q      <= '0;
      page_open_q <= 1'b0;
      bytes_q     <= '0;
      last_data_q <= 8'h00;
      last_addr_q <= '0;
    end
    else if (take && req.write)
    begin
      page_q      <= req.addr[14:`PAGE_LSB];
      page_open_q <= 1'b1;
      bytes_q     <= (state_q == S_IDLE) ? 7'd1 : bytes_q + 7'd1;
      last_data_q <= req.data;
      last_addr_q <= req.addr;
    end
    else if (state_q == S_POLL_ACC)
      page_open_q <= 1'b0;
  end

  // Poll sample: bit 7 matching the written data and bit 6 no longer flipping means done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      poll_hit_q <= 1'b0;
      tog_prev_q <= 1'b0;
    end
    else if (state_q == S_POLL_ACC && t_done)
    begin
      poll_hit_q <= (data_lines_i[`POLL_BIT] == last_data_q[`POLL_BIT])
                    && (data_lines_i[`TOGGLE_BIT] == tog_prev_q);
      tog_prev_q <= data_lines_i[`TOGGLE_BIT];
    end
  end

  // Request handshake and read answers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_ready  <= 1'b0;
      rd_valid   <= 1'b0;
      rd_data    <= 8'h00;
      wr_done    <= 1'b0;
      wr_timeout <= 1'b0;
    end
    else
    begin
      req_ready  <= 1'b0;
      rd_valid   <= 1'b0;
      wr_done    <= 1'b0;
      wr_timeout <= 1'b0;
      if (state_q == S_RD_ACC && t_done)
      begin
        rd_valid <= 1'b1;
        rd_data  <= data_lines_i;
      end
      if (state_q == S_POLL_FLOAT && t_done && poll_end)
      begin
        wr_done    <= 1'b1;
        wr_timeout <= !poll_hit_q;
      end
      // Next page byte only accepted on the same page
      if (state_q == S_IDLE && !req_ready && !take)
        req_ready <= 1'b1;
      else if (state_q == S_WAIT_NEXT && !take && blc_q > TW'(2))
        req_ready <= req_valid && same_page;
      else
        req_ready <= 1'b0;
    end
  end

  // Pin drive: write strobe only with output strobe high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pins            <= '{1'b1, 1'b1, 1'b1, 1'b0, 15'h0000};
      data_lines_o    <= 8'h00;
      data_lines_oe_n <= 1'b1;
    end
    else
    begin
      // Chip select falls with each command's write strobe as well
      pins.chip_sel_n <= !(state_q inside {S_WR_LOW, S_RD_ACC, S_POLL_ACC}
                           || (state_q == S_CMD && t_done)
                           || take);
      pins.out_en_n   <= !(state_q == S_RD_ACC || state_q == S_POLL_ACC
                           || (take && !req.write));
      pins.write_en_n <= !((state_q == S_WR_LOW && !t_done)
                           || (take && req.write)
                           || (state_q == S_CMD && t_done));
      data_lines_oe_n <= !(state_q inside {S_WR_LOW, S_WR_HIGH, S_CMD}
                           || (take && req.write));
      if (take)
      begin
        pins.id_area_sel   <= req.id_area;
        pins.address_lines <= req.write ? cmd_first[22:8]
                                        : req.addr;
        data_lines_o       <= req.write ? cmd_first[7:0]
                                        : 8'h00;
        if (state_q == S_WAIT_NEXT)
        begin
          pins.address_lines <= req.addr;
          data_lines_o       <= req.data;
        end
      end
      else if (state_q == S_WR_HIGH && t_done)
      begin
        if (in_cmd_q && cmd_idx_q != 2'd2)
        begin
          pins.address_lines <= cmd_next[22:8];
          data_lines_o       <= cmd_next[7:0];
        end
        else if (in_cmd_q)
        begin
          pins.address_lines <= last_addr_q;
          data_lines_o       <= last_data_q;
        end
      end
      else if (state_q == S_POLL_FLOAT && t_done)
        pins.address_lines <= last_addr_q;
    end
  end
endmodule

// file: common/eeprom_host_consts.svh
// Timing counts, command values and field positions for the EEPROM host
`ifndef EEPROM_HOST_CONSTS_SVH
`define EEPROM_HOST_CONSTS_SVH
`define CLK_PERIOD_PS      4000
`define WRITE_PULSE_NS     200
`define WRITE_HIGH_NS      100
`define READ_ACCESS_NS     200
`define DATA_FLOAT_NS      60
`define BYTE_LOAD_US       150
`define WRITE_CYCLE_MS     10
`define POWERUP_MS         10
`define WP_CYC ((`WRITE_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WH_CYC ((`WRITE_HIGH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RD_CYC ((`READ_ACCESS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define FL_CYC ((`DATA_FLOAT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BLC_CYC  ((`BYTE_LOAD_US * 1000000) / `CLK_PERIOD_PS)
`define WC_CYC   ((`WRITE_CYCLE_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define PU_CYC   ((`POWERUP_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define PAGE_BYTES         64
`define PAGE_LSB           6
`define POLL_BIT           7
`define TOGGLE_BIT         6
`define PROT_ADDR0         15'h5555
`define PROT_ADDR1         15'h2AAA
`define PROT_ADDR2         15'h5555
`define PROT_DATA0         8'hAA
`define PROT_DATA1         8'h55
`define PROT_DATA2         8'hA0
`endif

// file: common/eeprom_host_pkg.sv
// Types shared by the EEPROM host controller
package eeprom_host_pkg;
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_en_n;
    logic        write_en_n;
    logic        id_area_sel;
    logic [14:0] address_lines;
  } pin_ctl_s;
  typedef struct packed {
    logic        write;
    logic        id_area;
    logic [14:0] addr;
    logic [7:0]  data;
  } host_req_s;
endpackage

// file: hw/strobe_timer.sv
// Down counter that times one strobe phase or deadline
`timescale 1ns/1ps
module strobe_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  // Status
  output logic              done
);
  if (W < 1)
  begin
    $error("W must be at least 1");
  end

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  // Done must not look at load: callers derive load from done
  assign done = (cnt_q == '0);
endmodule

// file: verif/eeprom_host_asserts.sv
// Port checks of the EEPROM host controller
`timescale 1ns/1ps
module eeprom_host_asserts
  import eeprom_host_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Request side
  input wire logic       req_valid,
  input wire host_req_s  req,
  input wire logic       req_ready,
  input wire logic       rd_valid,
  input wire logic       wr_done,
  input wire logic       wr_timeout,
  // Device pins
  input wire pin_ctl_s   pins,
  input wire logic [7:0] data_lines_o,
  input wire logic       data_lines_oe_n
);
  wire we_n = pins.write_en_n;
  wire rd_go = req_valid && req_ready && !req.write;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_no_oe_write: assert property (
    !pins.out_en_n |-> we_n) else $error("write under read");
  chk_float_read: assert property (
    !data_lines_oe_n |-> pins.out_en_n) else $error("bus fight");
  chk_write_start: assert property (
    $fell(we_n) |-> !pins.chip_sel_n && pins.out_en_n)
    else $error("bad start");
  chk_addr_held: assert property (
    !we_n && !$past(we_n) |-> $stable(pins.address_lines))
    else $error("address moved");
  chk_data_held: assert property (
    !we_n && !$past(we_n) |-> $stable(data_lines_o) && !data_lines_oe_n)
    else $error("data moved");
  // Eight cycles is far above the glitch width yet cheap to unroll
  chk_pulse_width: assert property (
    $fell(we_n) |-> (!we_n)[*8]) else $error("short pulse");
  chk_read_strobes: assert property (
    rd_go |-> ##[1:2] !pins.chip_sel_n && !pins.out_en_n && we_n)
    else $error("read strobes");
  chk_read_answer: assert property (
    rd_go |-> ##[50:54] rd_valid) else $error("late read");
  chk_timeout_done: assert property (
    wr_timeout |-> wr_done) else $error("lone timeout");
  cover property (rd_valid);
  cover property (wr_done && !wr_timeout);
  cover property (pins.id_area_sel && !we_n);
endmodule
bind eeprom_host eeprom_host_asserts u_chk (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rd_valid(rd_valid), .wr_done(wr_done),
  .wr_timeout(wr_timeout), .pins(pins), .data_lines_o(data_lines_o),
  .data_lines_oe_n(data_lines_oe_n));

// file: verif/eeprom_dev_model.sv
// Behavioural model of the parallel EEPROM at the host's pins
`timescale 1ns/1ps
`include "eeprom_host_consts.svh"
module eeprom_dev_model #(
  parameter int BLC_NS  = 1000,
  parameter int PROG_NS = 3000
) (
  // Strobes and address
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_en_n,
  input wire logic        id_area_sel,
  input wire logic [14:0] address_lines,
  // Data
  input wire logic [7:0]  data_lines,
  output logic [7:0]      dev_data,
  output logic            dev_drive
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  idm [0:63];
  logic [7:0]  pbuf [0:63];
  logic [63:0] pmask = '0;
  logic [14:0] a_q;
  logic [8:0]  page;
  logic [7:0]  d_q, last;
  logic        id_q, pid, armed = 0, loading = 0, busy = 0, tog = 0;
  int          step = 0, nload = 0;
  time         t_fall, t_load, t_end;
  initial
    for (int k = 0; k < 32768; k++)
    begin
      mem[k] = 8'hFF;
      idm[k[5:0]] = 8'hFF;
    end
  assign dev_drive = !chip_sel_n && !out_en_n && write_en_n;
  // Polls answer for the last byte at any address, a simplification
  assign dev_data = busy ? {~last[7], tog, last[5:0]} :
    (id_area_sel && &address_lines[14:6]) ? idm[address_lines[5:0]] :
    mem[address_lines];
  always @(negedge dev_drive)
    if (busy)
      tog = ~tog;
  always @(negedge write_en_n or negedge chip_sel_n)
    if (!write_en_n && !chip_sel_n)
    begin
      a_q = address_lines;
      id_q = id_area_sel;
      t_fall = $time;
      armed = 1'b1;
    end
  always @(data_lines or write_en_n or chip_sel_n)
    if (!write_en_n && !chip_sel_n && out_en_n)
      d_q = data_lines;
  function automatic logic cmd_ok(input int s);
    case (s)
      0: return a_q == `PROT_ADDR0 && d_q == `PROT_DATA0;
      1: return a_q == `PROT_ADDR1 && d_q == `PROT_DATA1;
      default: return a_q == `PROT_ADDR2 && d_q == `PROT_DATA2;
    endcase
  endfunction
  always @(posedge write_en_n or posedge chip_sel_n)
    if (armed)
    begin
      armed = 1'b0;
      if (!out_en_n || busy || $time < 300 || $time - t_fall < 15)
        ;
      else if (step < 3 && cmd_ok(step))
        step++;
      else if (step < 3)
      begin
        // Write without the command prefix stores nothing yet holds the part busy
        last = d_q;
        busy = 1'b1;
        t_end = $time + PROG_NS;
      end
      else if (nload == 0 || a_q[14:6] == page)
      begin
        page = a_q[14:6];
        pid = id_q;
        pbuf[a_q[5:0]] = d_q;
        pmask[a_q[5:0]] = 1'b1;
        nload++;
        last = d_q;
        loading = 1'b1;
        t_load = $time;
      end
    end
  // A read ends the load early, so no poll sees a half-loaded page
  always #1
  begin
    if (loading && (dev_drive || nload == 64 || $time - t_load >= BLC_NS))
    begin
      loading = 1'b0;
      busy = 1'b1;
      t_end = $time + PROG_NS;
    end
    if (busy && $time >= t_end)
    begin
      for (int k = 0; k < 64; k++)
        if (pmask[k] && pid && &page)
          idm[k] = pbuf[k];
        else if (pmask[k])
          mem[{page, k[5:0]}] = pbuf[k];
      pmask = '0;
      nload = 0;
      step = 0;
      busy = 1'b0;
    end
  end
endmodule

// file: verif/eeprom_host_tb.sv
// Self-checking testbench of the EEPROM host controller
`timescale 1ns/1ps
module eeprom_host_tb;
  import eeprom_host_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       req_valid = 1'b0;
  logic       page_last = 1'b0;
  logic       flt_q = 1'b0;
  host_req_s  req = '0;
  logic       req_ready, rd_valid, wr_done, wr_timeout, oe_n, drv;
  logic [7:0] rd_data, d_o, d_dev, bus;
  pin_ctl_s   pins;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         i;
  time        t0;
  always #2 clk = ~clk;
  // Released bus toggles, so a stale value never reads back right
  always @(posedge clk) flt_q <= ~flt_q;
  assign bus = drv ? d_dev : (!oe_n ? d_o : {8{flt_q}});
  eeprom_host #(.WC_CYCLES(2000), .PU_CYCLES(100), .BLC_CYCLES(400)) dut (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .page_last(page_last), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_done(wr_done), .wr_timeout(wr_timeout),
    .pins(pins), .data_lines_o(d_o), .data_lines_oe_n(oe_n),
    .data_lines_i(bus));
  // Model deadline sits above the host's worst byte gap of 400 cycles
  eeprom_dev_model #(.BLC_NS(1700)) u_dev (
    .chip_sel_n(pins.chip_sel_n), .out_en_n(pins.out_en_n),
    .write_en_n(pins.write_en_n), .id_area_sel(pins.id_area_sel),
    .address_lines(pins.address_lines), .data_lines(bus),
    .dev_data(d_dev), .dev_drive(drv));
  task automatic complete_run();
    $display("%0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("ERROR %0t: no answer", $time);
    complete_run();
  endtask
  // Pulses are read 1 ns after the edge that raised them
  task automatic await(input logic wr);
    for (i = 0; i < 9000 && (wr ? wr_done : rd_valid) !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i >= 9000)
      give_up();
  endtask
  task automatic send(input logic w, input logic id, input logic [14:0] a,
                      input logic [7:0] d, input logic l);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req = '{w, id, a, d};
    page_last = l;
    // Ready seen after an edge stands for the next edge, the take edge
    for (i = 0; i < 9000 && req_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i >= 9000)
      give_up();
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic id, input logic [14:0] a,
                    output logic [7:0] q);
    send(1'b0, id, a, 8'h00, 1'b0);
    await(1'b0);
    q = rd_data;
  endtask
  task automatic t_powerup();
    logic [7:0] q;
    #1;
    rst = 1'b0;
    t0 = $time;
    rd(1'b0, 15'h0123, q);
    chk(q, 8'hFF);
    chk(8'(($time - t0) > 400), 8'h01);
    $display("power-up test done");
  endtask
  task automatic t_page();
    logic [7:0] q;
    send(1'b1, 1'b0, 15'h0A45, 8'h12, 1'b0);
    send(1'b1, 1'b0, 15'h0A41, 8'h34, 1'b0);
    send(1'b1, 1'b0, 15'h0A45, 8'h56, 1'b1);
    await(1'b1);
    chk({7'h0, wr_timeout}, 8'h00);
    rd(1'b0, 15'h0A45, q);
    chk(q, 8'h56);
    rd(1'b0, 15'h0A41, q);
    chk(q, 8'h34);
    rd(1'b0, 15'h0A42, q);
    chk(q, 8'hFF);
    rd(1'b0, 15'h5555, q);
    chk(q, 8'hFF);
    $display("page test done");
  endtask
  task automatic t_full();
    logic [7:0] q;
    for (int k = 0; k < 64; k++)
      send(1'b1, 1'b0, 15'h1C00 + 15'(k), 8'(k) ^ 8'h3C, 1'b0);
    await(1'b1);
    chk({7'h0, wr_timeout}, 8'h00);
    rd(1'b0, 15'h1C3F, q);
    chk(q, 8'h03);
    send(1'b1, 1'b0, 15'h1C00, 8'h77, 1'b1);
    await(1'b1);
    rd(1'b0, 15'h1C00, q);
    chk(q, 8'h77);
    $display("full page test done");
  endtask
  task automatic t_id();
    logic [7:0] q;
    send(1'b1, 1'b1, 15'h7FC5, 8'h0F, 1'b0);
    await(1'b1);
    rd(1'b1, 15'h7FC5, q);
    chk(q, 8'h0F);
    rd(1'b0, 15'h7FC5, q);
    chk(q, 8'hFF);
    $display("id area test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    t_powerup();
    t_page();
    t_full();
    t_id();
    complete_run();
  end
endmodule
